// File: adc_seq_pkg.sv
// Purpose: Shared constants for the converter sequence and buffer control block.
// Assumes: AXI4-Lite register access with 32-bit data and word-aligned offsets.
// Notes:   All offsets are byte addresses.
package adc_seq_pkg;
   localparam logic [3:0]  CTRL_OFF       = 4'h0;
   localparam logic [3:0]  STAT_OFF       = 4'h4;
   localparam logic [3:0]  MASK_OFF       = 4'h8;
   localparam logic [3:0]  SEL_OFF        = 4'hC;
   localparam int          OFFSET_CALIBRATION_SELECT_BIT     = 12;
   localparam int          SCAN_BIT       = 10;
   localparam int          FILL_BIT       = 7;
   localparam int          SEQUENCES_PER_INTERRUPT_LSB       = 2;
   localparam int          SPLIT_BIT      = 1;
   localparam int          ALT_BIT        = 0;
   localparam logic [31:0] CTRL_WR_MASK   = 32'h0000_F43F;
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
   localparam logic [31:0] SEL_RESET      = 32'h0000_0000;
   localparam int          STAT_SEQ_BIT   = 0;
   localparam logic [3:0]  HALF_WORDS_M1  = 4'h7;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage : adc_seq_pkg

// File: adc_sequence_buffer_control.sv
// Purpose: Control register, input routing, interrupt pacing and result buffer addressing.
// Assumes: The converter core pulses i_conv_done per sample and i_seq_done per sequence.
// Notes:   Software reaches the registers over AXI4-Lite.
//
// Notes on behaviour
// - Offset calibration ties both inputs to low reference.
// - Scan select steps through enabled inputs.
// - Fill status meaningful only in split mode.
// - Fill status shows which half is filling.
// - Interrupt every field-plus-one completed sequences.
// - Split mode gives two eight-word halves.
// - Alternate sample uses A, then B, A.
`timescale 1ns/100ps
module adc_sequence_buffer_control #(
   parameter int CH_W = 5
) (
   input  wire logic              i_core_clk,
   input  wire logic              i_rst_n,
   input  wire logic [3:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [3:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              i_conv_done,
   input  wire logic              i_seq_done,
   input  wire logic [CH_W-1:0]   i_scan_ch,
   output logic                   o_offset_cal,
   output logic                   o_scan_en,
   output logic                   o_use_mux_b,
   output logic [CH_W-1:0]        o_pos_ch,
   output logic [3:0]             o_buf_addr,
   output logic                   o_irq
);
   logic [31:0]     ctrl_r, ctrl_nxt;
   logic [31:0]     sel_r, sel_nxt;
   logic            stat_r, stat_nxt;
   logic            mask_r, mask_nxt;
   logic [3:0]      seq_cnt_r, seq_cnt_nxt;
   logic [3:0]      buf_addr_r, buf_addr_nxt;
   logic            fill_r, fill_nxt;
   logic            alt_b_r, alt_b_nxt;
   logic            aw_held_r, aw_held_nxt;
   logic [3:0]      aw_addr_r, aw_addr_nxt;
   logic            w_held_r, w_held_nxt;
   logic [31:0]     w_data_r, w_data_nxt;
   logic [3:0]      w_strb_r, w_strb_nxt;
   logic            bvalid_r, bvalid_nxt;
   logic [1:0]      bresp_r, bresp_nxt;
   logic            rvalid_r, rvalid_nxt;
   logic [31:0]     rdata_r, rdata_nxt;
   logic [1:0]      rresp_r, rresp_nxt;
   logic            irq_r, irq_nxt;
   logic            cal_r, cal_nxt;
   logic            scan_r, scan_nxt;
   logic            muxb_r, muxb_nxt;
   logic [CH_W-1:0] pos_r, pos_nxt;
   logic [31:0]     wmask;
   logic            do_write;
   logic            seq_hit;
   logic [3:0]      sequences_per_interrupt;

   assign sequences_per_interrupt = ctrl_r[adc_seq_pkg::SEQUENCES_PER_INTERRUPT_LSB +: 4];

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{w_strb_r[b]}};
      end
   end

   // Write and read bus channels; address and data may arrive in either order.
   always_comb begin
      aw_held_nxt = aw_held_r;
      aw_addr_nxt = aw_addr_r;
      w_held_nxt  = w_held_r;
      w_data_nxt  = w_data_r;
      w_strb_nxt  = w_strb_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      rvalid_nxt  = rvalid_r;
      rdata_nxt   = rdata_r;
      rresp_nxt   = rresp_r;
      do_write    = 1'b0;
      if (s_axi_awvalid && !aw_held_r) begin
         aw_held_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_r) begin
         w_held_nxt = 1'b1;
         w_data_nxt = s_axi_wdata;
         w_strb_nxt = s_axi_wstrb;
      end
      if (aw_held_r && w_held_r && !bvalid_r) begin
         do_write    = 1'b1;
         aw_held_nxt = 1'b0;
         w_held_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         unique case (aw_addr_r)
            adc_seq_pkg::CTRL_OFF, adc_seq_pkg::STAT_OFF,
            adc_seq_pkg::MASK_OFF, adc_seq_pkg::SEL_OFF: bresp_nxt = adc_seq_pkg::RESP_OKAY;
            default: bresp_nxt = adc_seq_pkg::RESP_SLVERR;
         endcase
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid && !rvalid_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = adc_seq_pkg::RESP_OKAY;
         rdata_nxt  = 32'h0000_0000;
         unique case (s_axi_araddr)
            adc_seq_pkg::CTRL_OFF: begin
               rdata_nxt = ctrl_r & adc_seq_pkg::CTRL_WR_MASK;
               rdata_nxt[adc_seq_pkg::FILL_BIT] = fill_r & ctrl_r[adc_seq_pkg::SPLIT_BIT];
            end
            adc_seq_pkg::STAT_OFF: rdata_nxt[adc_seq_pkg::STAT_SEQ_BIT] = stat_r;
            adc_seq_pkg::MASK_OFF: rdata_nxt[adc_seq_pkg::STAT_SEQ_BIT] = mask_r;
            adc_seq_pkg::SEL_OFF:  rdata_nxt = sel_r;
            default: rresp_nxt = adc_seq_pkg::RESP_SLVERR;
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   // Registers, interrupt pacing and result addressing.
   always_comb begin
      ctrl_nxt     = ctrl_r;
      sel_nxt      = sel_r;
      mask_nxt     = mask_r;
      stat_nxt     = stat_r;
      seq_cnt_nxt  = seq_cnt_r;
      buf_addr_nxt = buf_addr_r;
      fill_nxt     = fill_r;
      alt_b_nxt    = alt_b_r;
      seq_hit      = 1'b0;
      if (do_write) begin
         unique case (aw_addr_r)
            adc_seq_pkg::CTRL_OFF: begin
               // Only implemented bits take the write; fill status is read only.
               ctrl_nxt = (ctrl_r & ~(wmask & adc_seq_pkg::CTRL_WR_MASK)) |
                          (w_data_r & wmask & adc_seq_pkg::CTRL_WR_MASK);
               // A new configuration restarts pacing and buffer filling from the start.
               seq_cnt_nxt  = 4'h0;
               buf_addr_nxt = 4'h0;
               fill_nxt     = 1'b0;
               alt_b_nxt    = 1'b0;
            end
            adc_seq_pkg::STAT_OFF: begin
               if (w_strb_r[0] && w_data_r[adc_seq_pkg::STAT_SEQ_BIT]) begin
                  stat_nxt = 1'b0;
               end
            end
            adc_seq_pkg::MASK_OFF: begin
               if (w_strb_r[0]) begin
                  mask_nxt = w_data_r[adc_seq_pkg::STAT_SEQ_BIT];
               end
            end
            adc_seq_pkg::SEL_OFF: sel_nxt = (sel_r & ~wmask) | (w_data_r & wmask);
            default: ;
         endcase
      end
      // Only a control write, which restarts the state, drops a same-cycle event.
      // A status clear must not lose a sequence that ends under it.
      if (!(do_write && aw_addr_r == adc_seq_pkg::CTRL_OFF)) begin
         if (i_conv_done) begin
            alt_b_nxt = ctrl_r[adc_seq_pkg::ALT_BIT] & ~alt_b_r;
            if (ctrl_r[adc_seq_pkg::SPLIT_BIT] &&
                buf_addr_r[2:0] == adc_seq_pkg::HALF_WORDS_M1[2:0]) begin
               buf_addr_nxt = {~buf_addr_r[3], 3'h0};
               fill_nxt     = ~buf_addr_r[3];
            end else begin
               buf_addr_nxt = buf_addr_r + 4'h1;
            end
         end
         if (i_seq_done) begin
            if (seq_cnt_r == sequences_per_interrupt) begin
               seq_cnt_nxt = 4'h0;
               seq_hit     = 1'b1;
            end else begin
               seq_cnt_nxt = seq_cnt_r + 4'h1;
            end
            // Single-buffer mode wraps at each interrupt point so results start at word 0.
            if (seq_cnt_r == sequences_per_interrupt && !ctrl_r[adc_seq_pkg::SPLIT_BIT]) begin
               buf_addr_nxt = 4'h0;
            end
         end
      end
      if (seq_hit) begin
         stat_nxt = 1'b1; // Set wins over a same-cycle clear.
      end
   end

   // Front-end routing, registered so every output comes from a flip-flop.
   always_comb begin
      cal_nxt  = ctrl_nxt[adc_seq_pkg::OFFSET_CALIBRATION_SELECT_BIT];
      scan_nxt = ctrl_nxt[adc_seq_pkg::SCAN_BIT] & ~ctrl_nxt[adc_seq_pkg::OFFSET_CALIBRATION_SELECT_BIT];
      muxb_nxt = alt_b_nxt;
      if (scan_nxt && !alt_b_nxt) begin
         pos_nxt = i_scan_ch;
      end else if (alt_b_nxt) begin
         pos_nxt = sel_nxt[16 +: CH_W];
      end else begin
         pos_nxt = sel_nxt[0 +: CH_W];
      end
      irq_nxt = stat_nxt & mask_nxt;
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_r     <= adc_seq_pkg::CTRL_RESET;
         sel_r      <= adc_seq_pkg::SEL_RESET;
         mask_r     <= 1'b0;
         stat_r     <= 1'b0;
         seq_cnt_r  <= 4'h0;
         buf_addr_r <= 4'h0;
         fill_r     <= 1'b0;
         alt_b_r    <= 1'b0;
         aw_held_r  <= 1'b0;
         aw_addr_r  <= 4'h0;
         w_held_r   <= 1'b0;
         w_data_r   <= 32'h0000_0000;
         w_strb_r   <= 4'h0;
         bvalid_r   <= 1'b0;
         bresp_r    <= 2'h0;
         rvalid_r   <= 1'b0;
         rdata_r    <= 32'h0000_0000;
         rresp_r    <= 2'h0;
         irq_r      <= 1'b0;
         cal_r      <= 1'b0;
         scan_r     <= 1'b0;
         muxb_r     <= 1'b0;
         pos_r      <= '0;
      end else begin
         ctrl_r     <= ctrl_nxt;
         sel_r      <= sel_nxt;
         mask_r     <= mask_nxt;
         stat_r     <= stat_nxt;
         seq_cnt_r  <= seq_cnt_nxt;
         buf_addr_r <= buf_addr_nxt;
         fill_r     <= fill_nxt;
         alt_b_r    <= alt_b_nxt;
         aw_held_r  <= aw_held_nxt;
         aw_addr_r  <= aw_addr_nxt;
         w_held_r   <= w_held_nxt;
         w_data_r   <= w_data_nxt;
         w_strb_r   <= w_strb_nxt;
         bvalid_r   <= bvalid_nxt;
         bresp_r    <= bresp_nxt;
         rvalid_r   <= rvalid_nxt;
         rdata_r    <= rdata_nxt;
         rresp_r    <= rresp_nxt;
         irq_r      <= irq_nxt;
         cal_r      <= cal_nxt;
         scan_r     <= scan_nxt;
         muxb_r     <= muxb_nxt;
         pos_r      <= pos_nxt;
      end
   end

   assign s_axi_awready = ~aw_held_r;
   assign s_axi_wready  = ~w_held_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = ~rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign o_offset_cal  = cal_r;
   assign o_scan_en     = scan_r;
   assign o_use_mux_b   = muxb_r;
   assign o_pos_ch      = pos_r;
   assign o_buf_addr    = buf_addr_r;
   assign o_irq         = irq_r;
endmodule : adc_sequence_buffer_control

// File: adc_seq_ctrl_properties.sv
// Purpose: Port-level properties of the sequence and buffer control block.
// Assumes: A register write lands one edge after address and data are both taken.
// Notes:   Any pending write excuses a jump, since control writes restart the state.
`timescale 1ns/100ps
module adc_seq_ctrl_properties #(
   parameter int CH_W = 5
) (
   input  wire logic            i_core_clk,
   input  wire logic            i_rst_n,
   input  wire logic            s_axi_awvalid,
   input  wire logic            s_axi_wvalid,
   input  wire logic            s_axi_rvalid,
   input  wire logic            s_axi_rready,
   input  wire logic [31:0]     s_axi_rdata,
   input  wire logic            i_conv_done,
   input  wire logic            i_seq_done,
   input  wire logic [CH_W-1:0] i_scan_ch,
   input  wire logic            o_offset_cal,
   input  wire logic            o_scan_en,
   input  wire logic            o_use_mux_b,
   input  wire logic [CH_W-1:0] o_pos_ch,
   input  wire logic [3:0]      o_buf_addr,
   input  wire logic            o_irq
);
   wire wr_act = s_axi_awvalid | s_axi_wvalid;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_step;
      i_conv_done && !i_seq_done && !wr_act && !$past(wr_act);
   endsequence
   sequence s_quiet;
      !i_conv_done && !i_seq_done && !wr_act && !$past(wr_act);
   endsequence
   AST_CAL_NO_SCAN: assert property (o_offset_cal |-> !o_scan_en)
      else $error("scan active during offset calibration");
   AST_SCAN_CH: assert property ((o_scan_en and s_step) |=>
      o_use_mux_b || o_pos_ch == $past(i_scan_ch))
      else $error("scan channel not taken");
   AST_ADDR_HOLD: assert property (s_quiet |=> $stable(o_buf_addr))
      else $error("buffer address moved without a sample");
   AST_ADDR_STEP: assert property (s_step |=> o_buf_addr == $past(o_buf_addr) + 4'h1)
      else $error("buffer address did not step by one");
   AST_ALT_HOLD: assert property (!i_conv_done && !wr_act && !$past(wr_act) |=>
      $stable(o_use_mux_b))
      else $error("mux setting changed without a sample");
   AST_IRQ_RISE: assert property ($rose(o_irq) |->
      $past(i_seq_done) || $past(wr_act, 2))
      else $error("interrupt rose without cause");
   AST_IRQ_FALL: assert property ($fell(o_irq) |-> $past(wr_act, 2))
      else $error("interrupt fell without a write");
   AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer not held");
endmodule : adc_seq_ctrl_properties
bind adc_sequence_buffer_control adc_seq_ctrl_properties #(.CH_W(CH_W)) props_i (.*);

// File: conv_core_model.sv
// Purpose: Converter core model giving sample and sequence pulses.
// Assumes: The last sample of a sequence also ends that sequence.
// Notes:   The scan channel moves on every sample, as a real scan would.
`timescale 1ns/100ps
module conv_core_model #(
   parameter int CH_W = 5
) (
   input  wire logic            i_core_clk,
   output logic                 o_conv_done,
   output logic                 o_seq_done,
   output logic [CH_W-1:0]      o_scan_ch
);
   initial begin
      o_conv_done = 1'b0;
      o_seq_done  = 1'b0;
      o_scan_ch   = '0;
   end
   // One pulse per sample; gap zero gives back-to-back samples.
   task automatic run(input int n, input bit seq, input int gap);
      for (int k = 0; k < n; k++) begin
         o_conv_done <= 1'b1;
         o_seq_done  <= seq && (k == n - 1);
         @(posedge i_core_clk);
         o_scan_ch <= o_scan_ch + 1'b1;
         if (gap > 0 || k == n - 1) begin
            o_conv_done <= 1'b0;
            o_seq_done  <= 1'b0;
            repeat (gap) @(posedge i_core_clk);
         end
      end
   endtask : run
endmodule : conv_core_model

// File: tb_top.sv
// Purpose: Self-checking bench for the sequence and buffer control block.
// Assumes: Register map and latencies as handed over by the designer.
// Notes:   Waits are bounded by the watchdog alone, to keep the tasks short.
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
   $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb_top;
   logic i_core_clk, i_rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, i_conv_done, i_seq_done, o_offset_cal, o_scan_en, o_use_mux_b, o_irq;
   logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr, o_buf_addr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [4:0]  i_scan_ch, o_pos_ch, sc;
   int          error_cnt, tests_run, n;
   adc_sequence_buffer_control adc_sequence_buffer_control_i (.*);
   conv_core_model conv_core_model_i (.i_core_clk(i_core_clk), .o_conv_done(i_conv_done),
      .o_seq_done(i_seq_done), .o_scan_ch(i_scan_ch));
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize
   task automatic hs(ref logic rdy);
      logic t;
      do begin
         @(negedge i_core_clk);
         t = rdy;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge i_core_clk);
      end while (!t);
   endtask : hs
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge i_core_clk);
         ta |= s_axi_awready;
         tw |= s_axi_wready;
         @(posedge i_core_clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end while (!(ta && tw));
      hs(s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rc(input logic [3:0] a, input logic [31:0] e, input logic [1:0] p);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      hs(s_axi_arready);
      s_axi_arvalid <= 1'b0;
      // Ready comes a cycle late so the held answer is exercised.
      @(posedge i_core_clk);
      s_axi_rready <= 1'b1;
      hs(s_axi_rvalid);
      s_axi_rready <= 1'b0;
      `CHK(d, e)
      `CHK(r, p)
   endtask : rc
   initial begin
      i_core_clk = 1'b0;
      forever #2.5 i_core_clk = ~i_core_clk;
   end
   initial begin
      #50000;
      error_cnt++;
      summarize();
   end
   initial begin
      {i_rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      error_cnt = 0;
      tests_run = 0;
      repeat (10) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      for (int k = 0; k < 4; k++) rc(4'(4 * k), 32'h0, adc_seq_pkg::RESP_OKAY);
      rc(4'h2, 32'h0, adc_seq_pkg::RESP_SLVERR);
      wr(adc_seq_pkg::CTRL_OFF, 32'hFFFF_FFFF);
      rc(adc_seq_pkg::CTRL_OFF, 32'h0000_F43F, adc_seq_pkg::RESP_OKAY);
      `CHK({o_offset_cal, o_scan_en}, 2'h2)
      wr(adc_seq_pkg::CTRL_OFF, 32'h0000_0400);
      sc = i_scan_ch;
      conv_core_model_i.run(1, 0, 1);
      `CHK({o_offset_cal, o_scan_en, o_pos_ch}, {2'h1, sc})
      $display("test routing done");
      wr(adc_seq_pkg::SEL_OFF, 32'h0011_0003);
      wr(adc_seq_pkg::CTRL_OFF, 32'h0000_0001);
      for (int k = 0; k < 4; k++) begin
         conv_core_model_i.run(1, 0, 1);
         `CHK({o_use_mux_b, o_pos_ch}, k[0] ? 6'h03 : 6'h31)
      end
      wr(adc_seq_pkg::CTRL_OFF, 32'h0000_0000);
      conv_core_model_i.run(3, 0, 1);
      `CHK({o_use_mux_b, o_pos_ch}, 6'h03)
      $display("test alternation done");
      wr(adc_seq_pkg::CTRL_OFF, 32'h0000_0002);
      conv_core_model_i.run(8, 0, 0);
      @(posedge i_core_clk);
      `CHK(o_buf_addr, 4'h8)
      rc(adc_seq_pkg::CTRL_OFF, 32'h0000_0082, adc_seq_pkg::RESP_OKAY);
      conv_core_model_i.run(8, 0, 1);
      rc(adc_seq_pkg::CTRL_OFF, 32'h0000_0002, adc_seq_pkg::RESP_OKAY);
      wr(adc_seq_pkg::CTRL_OFF, 32'h0000_0000);
      conv_core_model_i.run(9, 0, 1);
      `CHK(o_buf_addr, 4'h9)
      rc(adc_seq_pkg::CTRL_OFF, 32'h0000_0000, adc_seq_pkg::RESP_OKAY);
      $display("test buffer done");
      conv_core_model_i.run(1, 1, 3);
      `CHK(o_irq, 1'b0)
      rc(adc_seq_pkg::STAT_OFF, 32'h1, adc_seq_pkg::RESP_OKAY);
      wr(adc_seq_pkg::STAT_OFF, 32'h1);
      wr(adc_seq_pkg::MASK_OFF, 32'h1);
      for (int k = 0; k < 3; k++) begin
         n = (k == 2) ? 15 : k;
         wr(adc_seq_pkg::CTRL_OFF, 32'(n) << 2);
         repeat (n) conv_core_model_i.run(1, 1, 3);
         `CHK(o_irq, 1'b0)
         conv_core_model_i.run(1, 1, 3);
         `CHK(o_irq, 1'b1)
         wr(adc_seq_pkg::STAT_OFF, 32'h1);
         rc(adc_seq_pkg::STAT_OFF, 32'h0, adc_seq_pkg::RESP_OKAY);
         `CHK(o_irq, 1'b0)
      end
      $display("test interrupt done");
      summarize();
   end
endmodule : tb_top
